//--- shared/snid_pkg.sv
// Purpose: constants and types for the native SIMD instruction decoder
// Assumes: 128-bit native instructions, 50 MHz core clock
// Notes:   register map is reached over AXI4-Lite
package snid_pkg;
  localparam int unsigned INSN_W = 128;
  // Doubleword positions inside the native instruction
  localparam int unsigned OPDW_LSB  = 0;
  localparam int unsigned DSTDW_LSB = 32;
  localparam int unsigned S0DW_LSB  = 64;
  localparam int unsigned S1DW_LSB  = 96;
  // Operation doubleword fields
  localparam int unsigned OPC_LSB   = 0;
  localparam int unsigned LAYOUT_B  = 8;
  localparam int unsigned PRED_LSB  = 16;
  localparam int unsigned PINV_B    = 20;
  localparam int unsigned EXW_LSB   = 21;
  localparam int unsigned COND_LSB  = 24;
  localparam int unsigned ACCW_B    = 28;
  localparam int unsigned CMPT_B    = 29;
  localparam int unsigned SAT_B     = 31;
  // Destination doubleword fields
  localparam int unsigned DRF_LSB   = 32;
  localparam int unsigned DTY_LSB   = 34;
  localparam int unsigned S0RF_LSB  = 37;
  localparam int unsigned S0TY_LSB  = 39;
  localparam int unsigned S1RF_LSB  = 42;
  localparam int unsigned S1TY_LSB  = 44;
  localparam int unsigned DMASK_LSB = 48;
  localparam int unsigned DREG_LSB  = 53;
  localparam int unsigned DAK_B     = 63;
  // Source doubleword fields, relative to the doubleword
  localparam int unsigned SREG_LSB  = 5;
  localparam int unsigned SMOD_LSB  = 13;
  localparam int unsigned SAK_B     = 15;
  localparam int unsigned SSUB_LSB  = 10;
  localparam int unsigned SIMM_LSB  = 0;
  localparam int unsigned SSWZ_LSB  = 0;
  // Three-source fields
  localparam int unsigned T3_S0_LSB = 64;
  localparam int unsigned T3_S1_LSB = 85;
  localparam int unsigned T3_S2_LSB = 106;
  localparam int unsigned T3_RSV0_B = 105;
  localparam int unsigned T3_RSV1_B = 84;
  localparam int unsigned T3_RSV2_B = 127;
  // Fields carrying meaning; others reserved
  localparam logic [127:0] USED_MASK = 128'h7FFFFFFF_FFFFFFFF_FFFFFFFF_FFFFFF7F;
  localparam logic [127:0] T3_USED   = 128'h3FFFFDFF_FFEFFFFF_FFFEBFFF_FFFFFF7F;
  // Register files and types
  localparam logic [1:0] RF_GENERAL = 2'h1;
  localparam logic [1:0] RF_IMM     = 2'h3;
  localparam logic [2:0] TY_UD = 3'h0, TY_D = 3'h1, TY_UW = 3'h2, TY_W = 3'h3;
  localparam logic [2:0] TY_UB = 3'h4, TY_B = 3'h5, TY_F = 3'h7;
  localparam logic [2:0] TY_UV = 3'h4, TY_VF = 3'h5, TY_V = 3'h6;
  localparam logic [3:0] COND_NONE  = 4'h0;
  localparam logic [3:0] COND_OVF   = 4'h8;
  // Opcodes
  localparam logic [6:0] OP_ILLEGAL = 7'h00;
  localparam logic [6:0] OP_MOV  = 7'h01;
  localparam logic [6:0] OP_SEL  = 7'h02;
  localparam logic [6:0] OP_NOT  = 7'h04;
  localparam logic [6:0] OP_AND  = 7'h05;
  localparam logic [6:0] OP_OR   = 7'h06;
  localparam logic [6:0] OP_CMP  = 7'h10;
  localparam logic [6:0] OP_JMPI = 7'h20;
  localparam logic [6:0] OP_IF   = 7'h22;
  localparam logic [6:0] OP_SEND = 7'h31;
  localparam logic [6:0] OP_SENDC= 7'h32;
  localparam logic [6:0] OP_MATH = 7'h38;
  localparam logic [6:0] OP_ADD  = 7'h40;
  localparam logic [6:0] OP_MUL  = 7'h41;
  localparam logic [6:0] OP_MAC  = 7'h48;
  localparam logic [6:0] OP_BFE  = 7'h18;
  localparam logic [6:0] OP_BFI2 = 7'h1A;
  localparam logic [6:0] OP_LRP  = 7'h5C;
  localparam logic [6:0] OP_MAD  = 7'h5B;
  localparam logic [6:0] OP_NOP  = 7'h7E;
  // Pipeline
  localparam int unsigned PIPE_LANES = 4;
  localparam int unsigned MAX_CH32   = 8;
  localparam int unsigned MAX_CH16   = 16;
  localparam int unsigned ACC_W      = 48;
  localparam int unsigned NUM_ADDR   = 8;
  // Register map (byte offsets)
  localparam logic [7:0] R_CTRL   = 8'h00;
  localparam logic [7:0] R_STATUS = 8'h04;
  localparam logic [7:0] R_ADDR0  = 8'h08;
  localparam logic [7:0] R_LASTOP = 8'h0C;
  localparam logic [7:0] R_COUNT  = 8'h10;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_DEC = 2'h3;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  typedef enum logic [1:0] {SNID_IDLE, SNID_RUN} snid_state_t;
endpackage

//--- rtl/snid_decoder.sv
// Purpose: native SIMD instruction decoder and issue sequencer
// Assumes: fetch supplies one 128-bit instruction with valid/ready
// Notes:   control and status over AXI4-Lite
// Operation
// - Overflow sets flags only, never traps
// - Max width 8 for 32-bit, 16 otherwise
// - Compressed two-source instruction splits into two halves
// - Each half sequenced over narrow pipe cycles
// - Source modifiers, swizzle; destination write mask
// - Flag is implied write/read destination
// - Wide per-thread accumulator, written by mac or accumulator-write bit
// - Indirect address is subregister plus offset
// - Eight 16-bit address subregisters, descriptor pair
// - At most one source of two may be immediate
// - Scalar immediate replicated across execution width
// - Vector immediates: 8x4-bit int, 4x8-bit float
// - Channel enable from mask, predicate, width
// - Execution width power of two, capped
// - 128-bit instruction, 126 bits used (121 in three-source layout)
// - Compact 64-bit form recognised, not expanded
// - Fields taken from their four doublewords
// - Three-source layout switches fields; special opcodes only suppress flag write
// - Three-source operands only general storage
// - Three-source uses dword subregs, swizzled layout
// - Operation doubleword same for every layout
// - Condition 0000 or compare leaves flags
// - Unlisted opcode decodes as illegal opcode
`timescale 1ns/1ps
`default_nettype none
module snid_decoder
  import snid_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          insn_valid,
  output logic               insn_ready,
  input  wire logic [127:0]  insn,
  output logic               issue_valid,
  input  wire logic          issue_ready,
  output logic [6:0]         issue_opcode,
  output logic [15:0]        issue_chan_en,
  output logic [255:0]       issue_second_source_operand_vec,
  output logic [7:0]         issue_dst_reg,
  output logic [7:0]         issue_first_source_operand_reg,
  output logic               issue_flag_write,
  output logic               issue_flag_read,
  output logic               issue_acc_write,
  output logic               issue_illegal_trap,
  output logic               issue_half,
  output logic [1:0]         issue_pass,
  output logic [3:0]         issue_src_mods,
  output logic [7:0]         issue_swizzle,
  input  wire logic [15:0]   pred_mask,
  input  wire logic [15:0]   exec_mask,
  input  wire logic [2:0]    addr_sel_w,
  input  wire logic [15:0]   addr_wdata,
  input  wire logic          addr_we,
  input  wire logic [31:0]   s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [31:0]   s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready
);
  import snid_pkg::*;

  function automatic logic legal_op(input logic [6:0] op);
    case (op)
      OP_MOV, OP_SEL, OP_NOT, OP_AND, OP_OR, OP_CMP, OP_JMPI, OP_IF,
      OP_SEND, OP_SENDC, OP_MATH, OP_ADD, OP_MUL, OP_MAC, OP_BFE,
      OP_BFI2, OP_LRP, OP_MAD, OP_NOP: legal_op = 1'b1;
      default: legal_op = 1'b0;
    endcase
  endfunction

  function automatic logic is_3src(input logic [6:0] op);
    is_3src = (op == OP_BFE) || (op == OP_BFI2) || (op == OP_LRP)
           || (op == OP_MAD);
  endfunction

  // Accessor for a whole 32-bit source doubleword, first or second
  function automatic logic [31:0] sdw(input logic [127:0] i,
                                      input logic one);
    sdw = one ? i[S1DW_LSB +: 32] : i[S0DW_LSB +: 32];
  endfunction

  // Control register: bit0 exception enable, bit1 stop accepting new instructions
  logic [31:0] ctrl, next_ctrl;
  logic [15:0] addr_sub [NUM_ADDR];
  logic [31:0] issued, next_issued;
  logic [31:0] sticky, next_sticky;

  // Instruction holding and sequencing
  snid_state_t state, next_state;
  logic [127:0] cur, next_cur;
  logic         half, next_half;
  logic [1:0]   pass, next_pass;
  logic         issue_valid_r, next_issue_valid;

  // Decode of the held instruction
  logic [127:0] clean;
  logic [6:0]   opc;
  logic         three, cmpt, compr, legal, special;
  logic [2:0]   exw_code, s0ty, s1ty;
  logic [1:0]   s1rf, s0rf, drf;
  logic [4:0]   exw, maxw, npass;
  logic         bad_fmt;
  logic [3:0]   cond;
  logic [15:0]  width_mask, chan_en;
  logic [255:0] second_source_operand_vec;
  logic [31:0]  imm;
  logic [7:0]   dst_reg, s0_reg;
  logic [31:0]  s0dw, s1dw;

  always_comb begin
    three    = is_3src(cur[OPC_LSB +: 7]);
    clean    = cur & (three ? T3_USED : USED_MASK);
    s0dw     = sdw(clean, 1'b0);
    s1dw     = sdw(clean, 1'b1);
    opc      = legal_op(clean[OPC_LSB +: 7]) ? clean[OPC_LSB +: 7]
               : OP_ILLEGAL;
    special  = (opc == OP_SEND) || (opc == OP_SENDC) || (opc == OP_MATH)
               || (opc == OP_JMPI) || (opc == OP_IF);
    cmpt     = clean[CMPT_B];
    compr    = clean[13:12] == 2'h1;
    exw_code = clean[EXW_LSB +: 3];
    cond     = clean[COND_LSB +: 4];
    drf      = clean[DRF_LSB +: 2];
    s0rf     = clean[S0RF_LSB +: 2];
    s1rf     = clean[S1RF_LSB +: 2];
    s0ty     = clean[S0TY_LSB +: 3];
    s1ty     = clean[S1TY_LSB +: 3];
    exw      = (exw_code > 3'h4) ? 5'h10 : 5'(5'h1 << exw_code);
    maxw     = (s0ty <= TY_D || s0ty == TY_F) ? 5'(MAX_CH32)
               : 5'(MAX_CH16);
    bad_fmt  = (exw_code > 3'h4) || (exw > maxw)
             || (s0rf == RF_IMM && s1rf == RF_IMM)
             || (three && (drf != RF_GENERAL || s0rf != RF_GENERAL
                 || s1rf != RF_GENERAL || !clean[LAYOUT_B]));
    legal    = legal_op(cur[OPC_LSB +: 7]);
    npass    = (exw > 5'(PIPE_LANES)) ? 5'(exw / 5'(PIPE_LANES)) : 5'h1;
    for (int i = 0; i < 16; i++) width_mask[i] = (5'(i) < exw);
    chan_en  = width_mask & exec_mask
               & (clean[PRED_LSB +: 4] == 4'h0 ? 16'hFFFF
                  : (clean[PINV_B] ? ~pred_mask : pred_mask))
               & (clean[LAYOUT_B] ? {4{clean[DMASK_LSB +: 4]}}
                  : 16'hFFFF);
    // Indirect: address subregister plus immediate offset
    if (clean[DAK_B])
      dst_reg = 8'(addr_sub[clean[DREG_LSB +: 3]] + clean[48 +: 5]);
    else
      dst_reg = clean[DREG_LSB +: 8];
    if (s0dw[SAK_B] && !three)
      s0_reg = 8'(addr_sub[s0dw[SSUB_LSB +: 3]]
               + s0dw[SREG_LSB +: 5]);
    else
      s0_reg = three ? clean[T3_S0_LSB + 12 +: 8]
               : s0dw[SREG_LSB +: 8];
    // Whole last doubleword; an immediate uses all 32 bits
    imm = cur[S1DW_LSB +: 32];
    for (int i = 0; i < 8; i++) begin
      case (s1ty)
        TY_V:  second_source_operand_vec[i*32 +: 32] = 32'($signed(imm[i*4 +: 4]));
        TY_VF: second_source_operand_vec[i*32 +: 32] = {24'h0, imm[(i%4)*8 +: 8]};
        default: second_source_operand_vec[i*32 +: 32] = imm;
      endcase
    end
  end

  always_comb begin
    next_state       = state;
    next_cur         = cur;
    next_half        = half;
    next_pass        = pass;
    next_issue_valid = issue_valid_r;
    next_issued      = issued;
    insn_ready       = (state == SNID_IDLE) && !ctrl[1];
    case (state)
      SNID_IDLE: begin
        if (insn_valid && insn_ready) begin
          next_cur         = insn;
          next_half        = 1'b0;
          next_pass        = 2'h0;
          next_issue_valid = 1'b1;
          next_state       = SNID_RUN;
        end
      end
      SNID_RUN: begin
        if (issue_ready) begin
          next_issued = issued + 32'h1;
          if (5'(pass) + 5'h1 < npass)
            next_pass = pass + 2'h1;
          else if (compr && !half && !three) begin
            next_half = 1'b1;
            next_pass = 2'h0;
          end else begin
            next_issue_valid = 1'b0;
            next_state       = SNID_IDLE;
          end
        end
      end
      default: next_state = SNID_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state         <= SNID_IDLE;
      cur           <= '0;
      half          <= 1'b0;
      pass          <= 2'h0;
      issue_valid_r <= 1'b0;
      issued        <= 32'h0;
    end else begin
      state         <= next_state;
      cur           <= next_cur;
      half          <= next_half;
      pass          <= next_pass;
      issue_valid_r <= next_issue_valid;
      issued        <= next_issued;
    end
  end

  logic illegal_now;
  assign illegal_now = !legal && ctrl[0];
  assign issue_valid        = issue_valid_r;
  assign issue_opcode       = opc;
  assign issue_chan_en      = chan_en;
  assign issue_second_source_operand_vec     = second_source_operand_vec;
  assign issue_dst_reg      = dst_reg;
  assign issue_first_source_operand_reg     = s0_reg;
  // No exception path for overflow; flags only
  assign issue_flag_write   = (cond != COND_NONE) && (opc != OP_CMP)
                              && !special;
  assign issue_flag_read    = clean[PRED_LSB +: 4] != 4'h0;
  assign issue_acc_write    = clean[ACCW_B] || opc == OP_MAC;
  assign issue_illegal_trap = issue_valid_r && illegal_now;
  assign issue_half         = half;
  assign issue_pass         = pass;
  assign issue_src_mods     = {s1dw[SMOD_LSB +: 2],
                               s0dw[SMOD_LSB +: 2]};
  assign issue_swizzle      = s0dw[SSWZ_LSB +: 8];

  // Address subregisters; side port write, 16-bit unsigned
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_ADDR; i++) addr_sub[i] <= 16'h0000;
    end else if (addr_we) begin
      addr_sub[addr_sel_w] <= addr_wdata;
    end
  end

  logic aw_hs, ar_hs;
  logic [31:0] awa;

  // Sticky status: bit0 illegal, bit1 bad format, bit2 compact
  always_comb begin
    next_sticky = sticky;
    if (aw_hs && awa[7:0] == R_STATUS && s_axi_wstrb[0])
      next_sticky = sticky & ~s_axi_wdata;
    if (state == SNID_RUN && issue_ready) begin
      next_sticky[0] = next_sticky[0] | !legal;
      next_sticky[1] = next_sticky[1] | bad_fmt;
      next_sticky[2] = next_sticky[2] | cmpt;
    end
  end

  // AXI4-Lite slave: one write, one read at a time
  logic        bvalid_r, rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  assign awa           = s_axi_awaddr;
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  assign s_axi_wready  = s_axi_awready;
  assign aw_hs         = s_axi_awready;
  assign s_axi_arready = s_axi_arvalid && !rvalid_r;
  assign ar_hs         = s_axi_arready;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_comb begin
    next_ctrl  = ctrl;
    next_bresp = bresp_r;
    next_rresp = rresp_r;
    next_rdata = rdata_r;
    if (aw_hs) begin
      next_bresp = RESP_OK;
      case (awa[7:0])
        R_CTRL: begin
          for (int b = 0; b < 4; b++)
            if (s_axi_wstrb[b]) next_ctrl[b*8 +: 8] = s_axi_wdata[b*8 +: 8];
        end
        R_STATUS: ;
        default: next_bresp = RESP_DEC;
      endcase
    end
    if (ar_hs) begin
      next_rresp = RESP_OK;
      case (s_axi_araddr[7:0])
        R_CTRL:   next_rdata = ctrl;
        R_STATUS: next_rdata = {sticky[31:3], sticky[2:0]};
        R_ADDR0:  next_rdata = {addr_sub[1], addr_sub[0]};
        R_LASTOP: next_rdata = {23'h0, state == SNID_RUN, 1'b0, opc};
        R_COUNT:  next_rdata = issued;
        default: begin
          next_rdata = 32'h0;
          next_rresp = RESP_DEC;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl     <= CTRL_RST;
      sticky   <= 32'h0;
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
      bresp_r  <= RESP_OK;
      rresp_r  <= RESP_OK;
      rdata_r  <= 32'h0;
    end else begin
      ctrl     <= next_ctrl;
      sticky   <= next_sticky;
      bvalid_r <= aw_hs ? 1'b1 : (s_axi_bready ? 1'b0 : bvalid_r);
      rvalid_r <= ar_hs ? 1'b1 : (s_axi_rready ? 1'b0 : rvalid_r);
      bresp_r  <= next_bresp;
      rresp_r  <= next_rresp;
      rdata_r  <= next_rdata;
    end
  end

  // Checks
  chk_illegal_map: assert property (@(posedge clk) disable iff (rst)
    !legal |-> issue_opcode == OP_ILLEGAL)
    else $error("unlisted opcode not mapped to illegal");
  chk_flag_none: assert property (@(posedge clk) disable iff (rst)
    cond == COND_NONE |-> !issue_flag_write)
    else $error("flag write with empty condition");
  chk_width_cap: assert property (@(posedge clk) disable iff (rst)
    issue_valid && !bad_fmt |-> $countones(width_mask) <= maxw)
    else $error("execution width above type limit");
  chk_seq_hold: assert property (@(posedge clk) disable iff (rst)
    issue_valid && !issue_ready |=> issue_valid && $stable(pass))
    else $error("issue dropped under back-pressure");
  chk_split_half: assert property (@(posedge clk) disable iff (rst)
    issue_valid && issue_ready && compr && !three && !half
    && 5'(pass) + 5'h1 >= npass |=> issue_valid && half && pass == 2'h0)
    else $error("compressed instruction not split");
  chk_chan_width: assert property (@(posedge clk) disable iff (rst)
    (issue_chan_en & ~width_mask) == 16'h0)
    else $error("channel beyond execution width");
  chk_imm_repl: assert property (@(posedge clk) disable iff (rst)
    s1ty == TY_UD |-> issue_second_source_operand_vec[255:224] == issue_second_source_operand_vec[31:0])
    else $error("immediate not replicated");
  chk_busy_ready: assert property (@(posedge clk) disable iff (rst)
    issue_valid |-> !insn_ready)
    else $error("new instruction taken while sequencing");
  chk_bresp_hold: assert property (@(posedge clk) disable iff (rst)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  cov_compr: cover property (@(posedge clk) disable iff (rst)
    issue_valid && half);
  cov_multi: cover property (@(posedge clk) disable iff (rst)
    issue_valid && pass == 2'h3);
  cov_illegal: cover property (@(posedge clk) disable iff (rst)
    issue_illegal_trap);
endmodule
`default_nettype wire

//--- sim/snid_pipe_model.sv
// Purpose: execution pipeline model that takes issued passes
// Assumes: one pass moves per issue_valid and issue_ready edge
// Notes:   with slow set it stalls on a shift-register pattern
`timescale 1ns/1ps
`default_nettype none
module snid_pipe_model (
  input  wire logic    clk,
  input  wire logic    rst,
  input  wire logic    issue_valid,
  input  wire logic    slow,
  output logic         issue_ready,
  output int unsigned  taken
);
  logic [31:0] sr;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sr          <= 32'h0000_5A5B;
      issue_ready <= 1'b0;
      taken       <= 0;
    end else begin
      sr          <= {sr[30:0], sr[31] ^ sr[21] ^ sr[1] ^ sr[0]};
      issue_ready <= !slow || sr[0];
      if (issue_valid && issue_ready) taken <= taken + 1;
    end
  end
endmodule
`default_nettype wire

//--- sim/tb.sv
// Purpose: self-checking bench for the native instruction decoder
// Assumes: masks held all ones, pipeline model may stall
// Notes:   expectations come from bench functions and the pipeline model's taken count
`timescale 1ns/1ps
`default_nettype none
module tb;
  import snid_pkg::*;
  logic         clk, rst, insn_valid, insn_ready, issue_valid, issue_ready;
  logic [127:0] insn;
  logic [6:0]   issue_opcode;
  logic [15:0]  issue_chan_en, pred_mask, exec_mask, addr_wdata;
  logic [255:0] issue_second_source_operand_vec;
  logic [7:0]   issue_dst_reg, issue_first_source_operand_reg, issue_swizzle;
  logic         issue_flag_write, issue_flag_read, issue_acc_write, exc;
  logic         issue_illegal_trap, issue_half, addr_we, slow;
  logic [1:0]   issue_pass, s_axi_bresp, s_axi_rresp, rr;
  logic [3:0]   issue_src_mods, s_axi_wstrb;
  logic [2:0]   addr_sel_w;
  logic [31:0]  s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic         s_axi_rvalid, s_axi_rready;
  logic [31:0]  seed, rd, r;
  logic [2:0]   ty_tab [4] = '{TY_UD, TY_VF, TY_F, TY_V};
  int unsigned  n_errors = 0, checks_done = 0, cycles = 0, taken;
  snid_decoder DUT (.clk(clk), .rst(rst), .insn_valid(insn_valid),
    .insn_ready(insn_ready), .insn(insn), .issue_valid(issue_valid),
    .issue_ready(issue_ready), .issue_opcode(issue_opcode),
    .issue_chan_en(issue_chan_en), .issue_second_source_operand_vec(issue_second_source_operand_vec),
    .issue_dst_reg(issue_dst_reg), .issue_first_source_operand_reg(issue_first_source_operand_reg),
    .issue_flag_write(issue_flag_write), .issue_flag_read(issue_flag_read),
    .issue_acc_write(issue_acc_write),
    .issue_illegal_trap(issue_illegal_trap), .issue_half(issue_half),
    .issue_pass(issue_pass), .issue_src_mods(issue_src_mods),
    .issue_swizzle(issue_swizzle), .pred_mask(pred_mask),
    .exec_mask(exec_mask), .addr_sel_w(addr_sel_w), .addr_wdata(addr_wdata),
    .addr_we(addr_we), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  snid_pipe_model PIPE (.clk(clk), .rst(rst), .issue_valid(issue_valid),
    .slow(slow), .issue_ready(issue_ready), .taken(taken));
  task automatic check(string what, logic [255:0] seen, logic [255:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [6:0] exp_op(logic [6:0] op);
    case (op)
      OP_MOV, OP_SEL, OP_NOT, OP_AND, OP_OR, OP_CMP, OP_JMPI, OP_IF, OP_SEND,
      OP_SENDC, OP_MATH, OP_ADD, OP_MUL, OP_MAC, OP_BFE, OP_BFI2, OP_LRP,
      OP_MAD, OP_NOP: return op;
      default: return OP_ILLEGAL;
    endcase
  endfunction
  function automatic logic [255:0] exp_vec(logic [2:0] ty, logic [31:0] w);
    logic [255:0] v;
    for (int i = 0; i < 8; i++) begin
      v[i*32 +: 32] = (ty == TY_V) ? {{28{w[i*4+3]}}, w[i*4 +: 4]}
                    : (ty == TY_VF) ? {24'h0, w[(i%4)*8 +: 8]} : w;
    end
    return v;
  endfunction
  function automatic logic [127:0] mk(logic [6:0] op, logic [2:0] w,
      logic [1:0] q, logic [3:0] cond, logic [2:0] ty, logic [31:0] imm);
    logic [127:0] x;
    x = '0;
    x[6:0] = op;
    x[13:12] = q;
    x[EXW_LSB +: 3] = w;
    x[COND_LSB +: 4] = cond;
    x[DRF_LSB +: 2] = RF_GENERAL;
    x[S0RF_LSB +: 2] = RF_GENERAL;
    x[S1RF_LSB +: 2] = RF_IMM;
    x[S1TY_LSB +: 3] = ty;
    x[DMASK_LSB +: 4] = 4'hF;
    x[127:96] = imm;
    x[DREG_LSB +: 8] = imm[7:0];
    x[S0DW_LSB +: 13] = imm[20:8];
    return x;
  endfunction
  task automatic send(logic [127:0] x);
    int unsigned t0, np;
    logic [2:0] w;
    w = x[EXW_LSB +: 3];
    np = (w < 3) ? 1 : 1 << (w - 2);
    if (x[13:12] == 2'h1) np = np * 2;
    @(posedge clk);
    t0 = taken;
    insn <= x;
    insn_valid <= 1'b1;
    do @(negedge clk); while (!insn_ready);
    @(posedge clk);
    insn_valid <= 1'b0;
    do @(negedge clk); while (!issue_valid);
    check("opcode", issue_opcode, exp_op(x[6:0]));
    check("trap", issue_illegal_trap, exp_op(x[6:0]) == 7'h00 && exc);
    check("acc_write", issue_acc_write, x[6:0] == OP_MAC);
    check("first_pass", {issue_half, issue_pass}, 3'h0);
    check("flag_read", issue_flag_read, x[PRED_LSB +: 4] != 0);
    if (x[COND_LSB +: 4] == COND_NONE)
      check("flag_write", issue_flag_write, 1'b0);
    if (x[6:0] == OP_ADD || x[6:0] == OP_MUL) begin
      check("second_source_operand_vec", issue_second_source_operand_vec, exp_vec(x[S1TY_LSB +: 3],
        x[127:96]));
      check("chan_en", issue_chan_en, (17'h1 << (1 << w)) - 1);
      check("dst_reg", issue_dst_reg, x[DREG_LSB +: 8]);
      check("first_source_operand_reg", issue_first_source_operand_reg, x[S0DW_LSB + SREG_LSB +: 8]);
      check("swizzle", issue_swizzle, x[S0DW_LSB + SSWZ_LSB +: 8]);
      check("flag_write", issue_flag_write, x[COND_LSB +: 4] != 0);
    end
    do @(negedge clk); while (taken != t0 + np);
    check("passes", issue_valid, 1'b0);
  endtask
  task automatic axw(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(negedge clk); while (!(s_axi_awready && s_axi_wready));
    @(posedge clk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(negedge clk); while (!s_axi_bvalid);
  endtask
  task automatic axr(logic [7:0] a, output logic [31:0] d,
      output logic [1:0] resp);
    @(posedge clk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    do @(negedge clk); while (!s_axi_arready);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    {insn_valid, insn, slow, addr_we, addr_sel_w, addr_wdata, exc} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_araddr, s_axi_arvalid} = '0;
    {pred_mask, exec_mask, s_axi_wstrb} = 36'hF_FFFF_FFFF;
    {s_axi_bready, s_axi_rready} = 2'h3;
    seed = 32'h7B31;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("idle_ready", insn_ready, 1'b1);
    check("idle_valid", issue_valid, 1'b0);
    for (int op = 0; op < 128; op++) send(mk(op[6:0], 3'h0, 2'h0, 4'h0,
      TY_UD, xs()));
    for (int i = 0; i < 40; i++) begin
      r = xs();
      slow <= r[8];
      send(mk(r[0] ? OP_ADD : OP_MUL, i == 0 ? 3'h3 : {1'b0, r[2:1]},
        {1'b0, r[4] | i == 0}, r[12:9], ty_tab[r[6:5]], xs()));
    end
    axr(R_COUNT, rd, rr);
    check("count", rd, taken);
    exc = 1'b1;
    axw(R_CTRL, 32'h0000_0001);
    send(mk(7'h7F, 3'h0, 2'h0, 4'h0, TY_UD, 32'h0));
    axr(R_STATUS, rd, rr);
    check("status_set", rd[0], 1'b1);
    axw(R_STATUS, 32'h0000_0001);
    axr(R_STATUS, rd, rr);
    check("status_clr", rd[0], 1'b0);
    axw(R_CTRL, 32'h0000_0002);
    check("halt", insn_ready, 1'b0);
    axw(R_CTRL, 32'h0000_0000);
    axr(8'h40, rd, rr);
    check("unmapped", {rr, rd}, {RESP_DEC, 32'h0});
    r = xs();
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      addr_we <= 1'b1;
      addr_sel_w <= i[2:0];
      addr_wdata <= r[i*16 +: 16];
    end
    @(posedge clk);
    addr_we <= 1'b0;
    axr(R_ADDR0, rd, rr);
    check("addr_pair", rd, r);
    report_and_stop();
  end
endmodule
`default_nettype wire
